// File: rtl/i2cw_defines.svh
/*
 Byte and bit counts, field positions and fixed values for the configuration write path.
 Assumes inclusion by bare name from the design files.
*/
`ifndef I2CW_DEFINES_SVH
`define I2CW_DEFINES_SVH
`define I2CW_ADDR_HI 4'h7
`define I2CW_OPC_WRITE 3'h3
`define I2CW_CMD_BYTES 3'h4
`define I2CW_DATA_BYTES 3'h4
`define I2CW_OPC_MSB 2
`define I2CW_PSEL_HI_BIT 0
`define I2CW_PSEL_LO_BIT 7
`define I2CW_BE_MSB 5
`define I2CW_BE_LSB 2
`define I2CW_AHI_MSB 1
`define I2CW_LAST_BIT 3'h7
`endif

// File: rtl/i2cw_pkg.sv
/*
 Types shared by the configuration write path.
 Assumes the defines header is compiled alongside.
*/
package i2cw_pkg;
	typedef struct packed {
		logic [1:0] port;
		logic [11:0] addr;
		logic [3:0] be;
		logic [31:0] data;
	} i2cw_wr_type;
	typedef enum logic [5:0] {
		I2CW_IDLE = 6'h01,
		I2CW_ADDR = 6'h02,
		I2CW_CMD = 6'h04,
		I2CW_DATA = 6'h08,
		I2CW_ACK = 6'h10,
		I2CW_SKIP = 6'h20
	} i2cw_state_type;
endpackage

// File: rtl/i2cw_sync.sv
/*
 Two-flop synchroniser for a bus of levels.
 Assumes inputs are asynchronous to core_clk_i.
*/
`timescale 1ns/1ps
module i2cw_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_reg <= {WIDTH{1'b1}};
			sync_reg <= {WIDTH{1'b1}};
		end
		else
		begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end
	assign sync_o = sync_reg;
endmodule

// File: rtl/i2cw_top.sv
/*
 I2C target write path: address phase, four command bytes, four data bytes, one
 register write strobe out. Assumes SCL and SDA are open-drain pins resolved
 outside, SCL far slower than core_clk_i, and straps static after reset.
*/
`timescale 1ns/1ps
`include "i2cw_defines.svh"
module i2cw_top (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic [2:0] addr_strap_i,
	output logic wr_valid_o,
	output i2cw_pkg::i2cw_wr_type wr_o,
	output logic [3:0] wr_port_sel_o,
	output logic busy_o
);
	// ============================================================
	// Input synchronisation and edge detection
	logic [4:0] sync_w;
	i2cw_sync #(.WIDTH(5)) u_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.async_i({addr_strap_i, scl_i, sda_i}),
		.sync_o(sync_w)
	);
	wire scl_s = sync_w[1];
	wire sda_s = sync_w[0];
	wire [2:0] strap_s = sync_w[4:2];
	logic scl_d_reg;
	logic sda_d_reg;
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end
	wire scl_rise = scl_s & ~scl_d_reg;
	wire scl_fall = ~scl_s & scl_d_reg;
	wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	// ============================================================
	// Byte framing state
	i2cw_pkg::i2cw_state_type state_reg;
	i2cw_pkg::i2cw_state_type state_next;
	i2cw_pkg::i2cw_state_type after_ack_reg;
	i2cw_pkg::i2cw_state_type after_ack_next;
	logic [7:0] shift_reg;
	logic [2:0] bit_reg;
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic [7:0] cmd0_reg;
	logic [7:0] cmd1_reg;
	logic [7:0] cmd2_reg;
	logic [7:0] cmd3_reg;
	logic [31:0] data_reg;
	logic ack_drive_reg;
	logic ack_drive_next;
	logic commit_reg;
	logic commit_next;
	logic wr_valid_reg;
	i2cw_pkg::i2cw_wr_type wr_reg;

	wire [7:0] byte_w = {shift_reg[6:0], sda_s};
	wire last_bit = scl_rise && (bit_reg == `I2CW_LAST_BIT);
	wire addr_hit = (byte_w[7:1] == {`I2CW_ADDR_HI, strap_s}) && !byte_w[0];

	wire op_ok = (cmd0_reg[`I2CW_OPC_MSB:0] == `I2CW_OPC_WRITE);
	wire [1:0] port_w = {cmd1_reg[`I2CW_PSEL_HI_BIT], cmd2_reg[`I2CW_PSEL_LO_BIT]};
	wire [3:0] be_w = cmd2_reg[`I2CW_BE_MSB:`I2CW_BE_LSB];
	wire [11:0] addr_w = {cmd2_reg[`I2CW_AHI_MSB:0], cmd3_reg, 2'b00};

	always_comb
	begin
		state_next = state_reg;
		after_ack_next = after_ack_reg;
		cnt_next = cnt_reg;
		ack_drive_next = ack_drive_reg;
		commit_next = 1'b0;
		case (state_reg)
			i2cw_pkg::I2CW_IDLE:
			begin
			end
			i2cw_pkg::I2CW_ADDR:
			begin
				if (last_bit)
				begin
					if (addr_hit)
					begin
						state_next = i2cw_pkg::I2CW_ACK;
						after_ack_next = i2cw_pkg::I2CW_CMD;
						cnt_next = 3'h0;
					end
					else
					begin
						state_next = i2cw_pkg::I2CW_IDLE;
					end
				end
			end
			i2cw_pkg::I2CW_CMD:
			begin
				if (last_bit)
				begin
					state_next = i2cw_pkg::I2CW_ACK;
					if (cnt_reg == `I2CW_CMD_BYTES - 3'h1)
					begin
						after_ack_next = i2cw_pkg::I2CW_DATA;
						cnt_next = 3'h0;
					end
					else
					begin
						after_ack_next = i2cw_pkg::I2CW_CMD;
						cnt_next = cnt_reg + 3'h1;
					end
				end
			end
			i2cw_pkg::I2CW_DATA:
			begin
				if (last_bit)
				begin
					state_next = i2cw_pkg::I2CW_ACK;
					if (cnt_reg == `I2CW_DATA_BYTES - 3'h1)
					begin
						after_ack_next = i2cw_pkg::I2CW_SKIP;
					end
					else
					begin
						after_ack_next = i2cw_pkg::I2CW_DATA;
						cnt_next = cnt_reg + 3'h1;
					end
				end
			end
			i2cw_pkg::I2CW_ACK:
			begin
				// SDA is pulled and released only on SCL falls, so the ack can never look like a START.
				if (scl_fall && ack_drive_reg)
				begin
					state_next = after_ack_reg;
					ack_drive_next = 1'b0;
					// Commit once, after fourth data ack
					commit_next = op_ok && (after_ack_reg == i2cw_pkg::I2CW_SKIP);
				end
				else if (scl_fall)
				begin
					ack_drive_next = 1'b1;
				end
			end
			i2cw_pkg::I2CW_SKIP:
			begin
				// Surplus bytes are not acted on and see NAK by releasing SDA.
			end
			default:
			begin
				state_next = i2cw_pkg::I2CW_IDLE;
			end
		endcase
		// STOP or repeated START ends the packet
		if (start_det)
		begin
			state_next = i2cw_pkg::I2CW_ADDR;
			ack_drive_next = 1'b0;
			commit_next = 1'b0;
		end
		else if (stop_det)
		begin
			state_next = i2cw_pkg::I2CW_IDLE;
			ack_drive_next = 1'b0;
			commit_next = 1'b0;
		end
	end

	// ============================================================
	// Registers
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_reg <= i2cw_pkg::I2CW_IDLE;
			after_ack_reg <= i2cw_pkg::I2CW_IDLE;
			cnt_reg <= 3'h0;
			ack_drive_reg <= 1'b0;
			commit_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			after_ack_reg <= after_ack_next;
			cnt_reg <= cnt_next;
			ack_drive_reg <= ack_drive_next;
			commit_reg <= commit_next;
		end
	end

	wire bit_clr = start_det | (state_reg == i2cw_pkg::I2CW_ACK);
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			shift_reg <= 8'h00;
			bit_reg <= 3'h0;
		end
		else if (bit_clr)
		begin
			bit_reg <= 3'h0;
		end
		else if (scl_rise)
		begin
			shift_reg <= byte_w;
			bit_reg <= bit_reg + 3'h1;
		end
	end

	wire cmd_take = last_bit && (state_reg == i2cw_pkg::I2CW_CMD);
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cmd0_reg <= 8'h00;
			cmd1_reg <= 8'h00;
			cmd2_reg <= 8'h00;
			cmd3_reg <= 8'h00;
		end
		else if (cmd_take)
		begin
			cmd0_reg <= (cnt_reg == 3'h0) ? byte_w : cmd0_reg;
			cmd1_reg <= (cnt_reg == 3'h1) ? byte_w : cmd1_reg;
			cmd2_reg <= (cnt_reg == 3'h2) ? byte_w : cmd2_reg;
			cmd3_reg <= (cnt_reg == 3'h3) ? byte_w : cmd3_reg;
		end
	end

	// Data shifts in most significant byte first
	wire data_take = last_bit && (state_reg == i2cw_pkg::I2CW_DATA);
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			data_reg <= 32'h0000_0000;
		end
		else if (data_take)
		begin
			data_reg <= {data_reg[23:0], byte_w};
		end
	end

	// The strobe waits for the ack clock to end, so a STOP cannot cut a write half done.
	wire fire = commit_reg;
	logic pend_reg;
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pend_reg <= 1'b0;
			wr_valid_reg <= 1'b0;
			wr_reg <= '0;
		end
		else
		begin
			// Invalid opcode never reaches the strobe
			pend_reg <= fire;
			wr_valid_reg <= pend_reg;
			if (pend_reg)
			begin
				wr_reg <= '{port: port_w, addr: addr_w, be: be_w, data: data_reg};
			end
		end
	end

	// ============================================================
	// Outputs
	assign sda_o = 1'b0;
	assign sda_oe_n_o = ~ack_drive_reg;
	assign wr_valid_o = wr_valid_reg;
	assign wr_o = wr_reg;
	assign wr_port_sel_o = wr_valid_reg ? (4'h1 << wr_reg.port) : 4'h0;
	assign busy_o = (state_reg != i2cw_pkg::I2CW_IDLE);
endmodule

// File: verif/i2cw_master.sv
/* Bus master model with 200 ns serial clock.
 Assumes a pull-up on the data line. */
`timescale 1ns/1ps
module i2cw_master (
	input wire logic dev_oe_n_i,
	output logic scl_o,
	output logic sda_o
);
	logic drv;
	assign sda_o = drv & dev_oe_n_i;
	initial
	begin
		scl_o = 1'b1;
		drv = 1'b1;
	end
	task automatic start();
		drv = 1'b1;
		#100 scl_o = 1'b1;
		#100 drv = 1'b0;
		#100 scl_o = 1'b0;
	endtask
	task automatic stop();
		drv = 1'b0;
		#100 scl_o = 1'b1;
		#100 drv = 1'b1;
		#100;
	endtask
	// byte then ack clock; the 100 ns low phase before the next rise lets the target release in time.
	task automatic wbyte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			drv = b[i];
			#100 scl_o = 1'b1;
			#100 scl_o = 1'b0;
		end
		drv = 1'b1;
		#100 scl_o = 1'b1;
		#50 ack = sda_o;
		#50 scl_o = 1'b0;
	endtask
endmodule

// File: verif/i2cw_top_properties.sv
/* Output checker of the write path.
 Assumes a bind onto i2cw_top. */
`timescale 1ns/1ps
module i2cw_top_properties (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire logic [2:0] addr_strap_i,
	input wire logic wr_valid_o,
	input wire i2cw_pkg::i2cw_wr_type wr_o,
	input wire logic [3:0] wr_port_sel_o,
	input wire logic busy_o
);
	// ====
	// Checks.
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_one; wr_valid_o |=> !wr_valid_o; endproperty
	a_one: assert property (p_one) else $error("long strobe");
	property p_sel; wr_valid_o |-> wr_port_sel_o == 4'h1 << wr_o.port; endproperty
	a_sel: assert property (p_sel) else $error("port select");
	property p_nsel; !wr_valid_o |-> wr_port_sel_o == 4'h0; endproperty
	a_nsel: assert property (p_nsel) else $error("stray select");
	property p_alo; wr_valid_o |-> wr_o.addr[1:0] == 2'h0; endproperty
	a_alo: assert property (p_alo) else $error("address low bits");
	property p_hold; $changed(wr_o) |-> wr_valid_o; endproperty
	a_hold: assert property (p_hold) else $error("write bus moved");
	property p_busy; wr_valid_o || !sda_oe_n_o |-> busy_o; endproperty
	a_busy: assert property (p_busy) else $error("idle activity");
	property p_od; !sda_oe_n_o |-> !sda_o; endproperty
	a_od: assert property (p_od) else $error("data not low");
	property p_ack; $fell(sda_oe_n_o) |=> !sda_oe_n_o [*3]; endproperty
	a_ack: assert property (p_ack) else $error("short ack");
endmodule
bind i2cw_top i2cw_top_properties i_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .addr_strap_i(addr_strap_i),
	.wr_valid_o(wr_valid_o), .wr_o(wr_o), .wr_port_sel_o(wr_port_sel_o), .busy_o(busy_o));

// File: verif/i2cw_top_tb.sv
/* Testbench of the write path.
 Assumes the checker bound and the master model. */
`timescale 1ns/1ps
module i2cw_top_tb;
	logic core_clk_i, rst_n_i, scl, sda, sda_o, sda_oe_n_o, wr_valid_o, busy_o;
	logic [2:0] addr_strap_i;
	logic [3:0] wr_port_sel_o;
	i2cw_pkg::i2cw_wr_type wr_o, cap;
	int errors, tests_run, pulses;
	i2cw_top i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o), .addr_strap_i(addr_strap_i), .wr_valid_o(wr_valid_o), .wr_o(wr_o),
		.wr_port_sel_o(wr_port_sel_o), .busy_o(busy_o));
	i2cw_master i_mst (.dev_oe_n_i(sda_oe_n_o), .scl_o(scl), .sda_o(sda));
	initial
	begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i)
		if (wr_valid_o === 1'b1)
		begin
			pulses++;
			cap = wr_o;
		end
	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task stop_test();
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ====
	// Packet sender; bytes from index nak on expect no acknowledge.
	task automatic pkt(input logic [6:0] a, input logic [71:0] by, input int n, input int nak, input bit fin);
		logic ack;
		pulses = 0;
		i_mst.start();
		for (int k = 0; k <= n; k++)
		begin
			i_mst.wbyte(k == 0 ? {a, 1'b0} : by[79 - 8 * k -: 8], ack);
			chk("ack", 64'(k >= nak), 64'(ack));
		end
		if (fin)
		begin
			i_mst.stop();
			for (int i = 0; i < 40 && busy_o !== 1'b0; i++)
				@(negedge core_clk_i);
			chk("busy", 0, busy_o);
		end
		else
			repeat (12) @(negedge core_clk_i);
	endtask
	task expw(input int np, input logic [49:0] e);
		chk("pulses", np, pulses);
		if (np > 0)
			chk("write", e, cap);
	endtask
	task t_plain();
		pkt(7'h38, 72'h03003C2D12345678EE, 8, 99, 1);
		expw(1, {2'h0, 12'h0B4, 4'hF, 32'h12345678});
		$display("plain done");
	endtask
	task t_ports();
		for (int p = 0; p < 4; p++)
		begin
			@(negedge core_clk_i);
			addr_strap_i = 3'(p + 5);
			repeat (4) @(negedge core_clk_i);
			pkt({4'h7, 3'(p + 5)}, {8'hFB, 7'h60, 1'(p >> 1), 1'(p), 1'h1, 4'h1 << p, 2'(p), 8'hA5 ^ 8'(p),
				32'hA1B2C3D4 + p, 8'h00}, 8, 99, 1);
			expw(1, {2'(p), 2'(p), 8'hA5 ^ 8'(p), 2'h0, 4'h1 << p, 32'hA1B2C3D4 + p});
		end
		$display("ports done");
	endtask
	task t_codes();
		for (int op = 0; op < 8; op++)
		begin
			pkt(7'h38, {5'h00, 3'(op), 24'h003C00, 40'h1122334455}, 8, 99, 1);
			expw(op == 3, {2'h0, 12'h000, 4'hF, 32'h11223344});
		end
		$display("codes done");
	endtask
	task t_edges();
		pkt(7'h38, 72'h03013C0000000000AA, 9, 9, 1);
		expw(1, {2'h2, 12'h000, 4'hF, 32'h00000000});
		pkt(7'h3D, 72'h0, 0, 0, 1);
		expw(0, 50'h0);
		pkt(7'h38, 72'h03013C00AABBCCDD00, 7, 99, 1);
		expw(0, 50'h0);
		pkt(7'h38, 72'h0300BC0101020304EE, 8, 99, 0);
		expw(1, {2'h1, 12'h004, 4'hF, 32'h01020304});
		pkt(7'h38, 72'h0300A40201020304EE, 8, 99, 1);
		expw(1, {2'h1, 12'h008, 4'h9, 32'h01020304});
		$display("edges done");
	endtask
	initial
	begin
		rst_n_i = 1'b0;
		addr_strap_i = 3'h0;
		errors = 0;
		tests_run = 0;
		repeat (10) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge core_clk_i);
		t_plain();
		t_ports();
		t_codes();
		t_edges();
		stop_test();
	end
	initial
	begin
		#2000000;
		errors++;
		stop_test();
	end
endmodule
